//--- design/scp_prescaler.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module scp_prescaler (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire scp_pkg::scp_bus_req_t req_i,
  output logic [7:0] rdata_o,
  // fuse and factory straps
  input wire logic startup_divide_by_eight_fuse_i, // 1 = programmed
  input wire logic [7:0] trim_factory_i, // calibration value
  // clock availability logic
  input wire logic avail_confirm_i, // one-cycle pulse: source stable
  // outputs to the clock system
  output scp_pkg::scp_clk_en_t clk_en_o, // active edge enables
  output logic [7:0] rc_oscillator_trim_o, // to the rc oscillator
  output scp_pkg::scp_cmd_out_t cmd_o // to the clock switch logic
);

  // --------------------------------------------------------------------
  // decode and unlocks
  // --------------------------------------------------------------------

  logic wr_div; // write to clock_divide_control
  logic wr_cmd; // write to clock_command_status
  logic wr_trim; // write to rc_oscillator_trim
  logic div_open; // divide_change_unlock
  logic div_fwr; // divide_select write accepted
  logic cmd_open; // command_change_unlock
  logic cmd_fwr; // clock_command_code write accepted

  assign wr_div = req_i.wr && req_i.addr == scp_pkg::SCP_DIVCTL_OFS;
  assign wr_cmd = req_i.wr && req_i.addr == scp_pkg::SCP_CMDSTS_OFS;
  assign wr_trim = req_i.wr && req_i.addr == scp_pkg::SCP_TRIM_OFS;

  // divide register unlock
  scp_unlock #(
    .WINDOW(scp_pkg::SCP_UNLOCK_WINDOW_CYC)
  ) u_div_unlock (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(wr_div),
    .wdata_i(req_i.wdata),
    .open_o(div_open),
    .field_wr_o(div_fwr)
  );

  // command register unlock, same timing
  scp_unlock #(
    .WINDOW(scp_pkg::SCP_UNLOCK_WINDOW_CYC)
  ) u_cmd_unlock (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(wr_cmd),
    .wdata_i(req_i.wdata),
    .open_o(cmd_open),
    .field_wr_o(cmd_fwr)
  );

  // --------------------------------------------------------------------
  // divide select and pending change
  // --------------------------------------------------------------------

  logic [3:0] divide_select_q; // software view of the code
  logic [3:0] act_code_q; // code the counter runs on
  logic [3:0] pend_code_q; // code waiting for a period boundary
  logic pend_q; // change waiting
  logic [7:0] cnt_q; // ripple counter image, not readable
  logic boundary; // last master cycle of the current period

  // divide code to counter terminal value, 2**code - 1
  function automatic logic [7:0] mask_of(input logic [3:0] code);
    logic [8:0] p;
    p = 9'h001 << code;
    mask_of = 8'(p - 9'h001);
  endfunction

  assign boundary = (cnt_q == mask_of(act_code_q));

  // software-visible divide code
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      divide_select_q <= startup_divide_by_eight_fuse_i ?
        scp_pkg::SCP_DIVSEL_RST_DIV8 : scp_pkg::SCP_DIVSEL_RST_PLAIN;
    end else if (div_fwr) begin
      divide_select_q <= req_i.wdata[3:0];
    end
  end

  // pending change, taken over only at a period boundary
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      pend_code_q <= scp_pkg::SCP_DIVSEL_RST_PLAIN;
    end else if (div_fwr && req_i.wdata[3:0] <= scp_pkg::SCP_DIVSEL_MAX) begin
      // a new legal code wins over a boundary in the same cycle
      pend_q <= 1'b1;
      pend_code_q <= req_i.wdata[3:0];
    end else if (boundary) begin
      pend_q <= 1'b0;
    end
  end

  // active code; reserved codes never get here
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      act_code_q <= startup_divide_by_eight_fuse_i ?
        scp_pkg::SCP_DIVSEL_RST_DIV8 : scp_pkg::SCP_DIVSEL_RST_PLAIN;
    end else if (boundary && pend_q) begin
      act_code_q <= pend_code_q;
    end
  end

  // --------------------------------------------------------------------
  // divider
  // --------------------------------------------------------------------

  // counter on the undivided clock; restarts with each new period so
  // a switch never shortens the period in progress
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (boundary) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // one active edge per period, identical for every domain
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_en_o <= '0;
    end else begin
      clk_en_o.cpu <= boundary;
      clk_en_o.flash <= boundary;
      clk_en_o.io <= boundary;
      clk_en_o.adc <= boundary;
    end
  end

  // --------------------------------------------------------------------
  // oscillator trim
  // --------------------------------------------------------------------

  // factory value at reset, software may overwrite; bit 7 picks the
  // range and bits 6:0 tune inside it, both passed straight through
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rc_oscillator_trim_o <= trim_factory_i;
    end else if (wr_trim) begin
      rc_oscillator_trim_o <= req_i.wdata;
    end
  end

  // --------------------------------------------------------------------
  // command and status
  // --------------------------------------------------------------------

  logic [3:0] cmd_code_q; // clock_command_code
  logic ready_q; // source_ready_flag
  logic ready_clr; // availability request or enable entered

  assign ready_clr = cmd_fwr && (req_i.wdata[3:0] == scp_pkg::SCP_CMD_AVAIL_REQ ||
    req_i.wdata[3:0] == scp_pkg::SCP_CMD_ENABLE);

  // command field
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_code_q <= scp_pkg::SCP_CMD_RST;
    end else if (cmd_fwr) begin
      cmd_code_q <= req_i.wdata[3:0];
    end
  end

  // command pulse; codes with the top bit set are no command
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_o <= '{valid: 1'b0, code: scp_pkg::SCP_CMD_NONE};
    end else begin
      cmd_o.valid <= cmd_fwr && !req_i.wdata[3] &&
        req_i.wdata[3:0] != scp_pkg::SCP_CMD_NONE;
      cmd_o.code <= req_i.wdata[3] ? scp_pkg::SCP_CMD_NONE :
        scp_pkg::scp_cmd_t'(req_i.wdata[3:0]);
    end
  end

  // ready flag: confirmation wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else if (avail_confirm_i) begin
      ready_q <= 1'b1;
    end else if (ready_clr) begin
      ready_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------

  // data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge mclk_i) begin
    if (rst_i || !req_i.rd) begin
      rdata_o <= 8'h00;
    end else begin
      case (req_i.addr)
        scp_pkg::SCP_DIVCTL_OFS: begin
          rdata_o <= {div_open, 3'b000, divide_select_q};
        end
        scp_pkg::SCP_CMDSTS_OFS: begin
          rdata_o <= {cmd_open, 2'b00, ready_q, cmd_code_q};
        end
        scp_pkg::SCP_TRIM_OFS: begin
          rdata_o <= rc_oscillator_trim_o;
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------

  logic [8:0] gap_q; // cycles since last active edge
  logic [7:0] hold_mask_q; // terminal value at last active edge
  logic seen_q; // one active edge seen since reset

  // spacing helper
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gap_q <= 9'h000;
      hold_mask_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (clk_en_o.cpu) begin
      gap_q <= 9'h000;
      hold_mask_q <= mask_of(act_code_q);
      seen_q <= 1'b1;
    end else if (gap_q != 9'h1ff) begin
      gap_q <= gap_q + 9'h001;
    end
  end

  sequence s_unlock_write;
    wr_div && req_i.wdata == scp_pkg::SCP_UNLOCK_PATTERN && !div_open;
  endsequence

  sequence s_window_then_close;
    div_open [*1] ##3 1'b1 ##1 !div_open;
  endsequence

  property p_div_window;
    @(posedge mclk_i) disable iff (rst_i)
      s_unlock_write |=> s_window_then_close;
  endproperty
  a_div_window: assert property (p_div_window) else $error("divide unlock window wrong");

  property p_div_rise_cause;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(div_open) |-> $past(wr_div) &&
        $past(req_i.wdata) == scp_pkg::SCP_UNLOCK_PATTERN;
  endproperty
  a_div_rise_cause: assert property (p_div_rise_cause) else $error("stray unlock");

  property p_div_no_extend;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(div_open) |-> ##4 !div_open;
  endproperty
  a_div_no_extend: assert property (p_div_no_extend) else $error("window extended");

  property p_div_close_on_write;
    @(posedge mclk_i) disable iff (rst_i)
      div_open && wr_div && !req_i.wdata[7] |=>
        !div_open && divide_select_q == $past(req_i.wdata[3:0]);
  endproperty
  a_div_close_on_write: assert property (p_div_close_on_write) else $error("bad code");

  property p_cmd_window;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(cmd_open) |-> cmd_open [*4] ##1 !cmd_open or ##[1:4] !cmd_open;
  endproperty
  a_cmd_window: assert property (p_cmd_window) else $error("command unlock wrong");

  property p_reserved_keep;
    @(posedge mclk_i) disable iff (rst_i)
      div_fwr && req_i.wdata[3:0] > scp_pkg::SCP_DIVSEL_MAX && !pend_q |=>
        !pend_q && $stable(act_code_q);
  endproperty
  a_reserved_keep: assert property (p_reserved_keep) else $error("reserved applied");

  property p_reset_code;
    @(posedge mclk_i)
      rst_i |=> divide_select_q == ($past(startup_divide_by_eight_fuse_i) ?
        scp_pkg::SCP_DIVSEL_RST_DIV8 : scp_pkg::SCP_DIVSEL_RST_PLAIN);
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("reset code wrong");

  property p_reset_trim;
    @(posedge mclk_i)
      rst_i |=> rc_oscillator_trim_o == $past(trim_factory_i);
  endproperty
  a_reset_trim: assert property (p_reset_trim) else $error("trim not loaded");

  property p_no_fast_edge;
    @(posedge mclk_i) disable iff (rst_i)
      clk_en_o.cpu && seen_q |->
        gap_q >= {1'b0, (hold_mask_q < mask_of(act_code_q)) ?
          hold_mask_q : mask_of(act_code_q)};
  endproperty
  a_no_fast_edge: assert property (p_no_fast_edge) else $error("edge too early");

  property p_reserved_read;
    @(posedge mclk_i) disable iff (rst_i)
      req_i.rd && req_i.addr == scp_pkg::SCP_DIVCTL_OFS |=> rdata_o[6:4] == 3'b000;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set");

  property p_ready_set;
    @(posedge mclk_i) disable iff (rst_i)
      avail_confirm_i |=> ready_q;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set");

endmodule

//--- design/scp_unlock.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// timed change unlock: opens on the unlock pattern, closes after a
// fixed window or when the guarded field is written
// ----------------------------------------------------------------------
module scp_unlock #(
  parameter int WINDOW = scp_pkg::SCP_UNLOCK_WINDOW_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // write decode
  input wire logic wr_i, // write to the guarded register
  input wire logic [7:0] wdata_i, // write data
  // state
  output logic open_o, // window open
  output logic field_wr_o // guarded field write accepted now
);

  // window cycle counter
  logic [3:0] cnt_q;
  logic open_q;

  // field write only with the window open and unlock bit written zero
  assign field_wr_o = open_q && wr_i && !wdata_i[scp_pkg::SCP_UNLOCK_POS];
  assign open_o = open_q;

  // window state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      open_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (open_q) begin
      // rewriting the pattern here neither restarts nor clears
      if (field_wr_o || cnt_q == 4'(WINDOW - 1)) begin
        open_q <= 1'b0;
      end
      cnt_q <= cnt_q + 4'h1;
    end else if (wr_i && wdata_i == scp_pkg::SCP_UNLOCK_PATTERN) begin
      open_q <= 1'b1;
      cnt_q <= 4'h0;
    end
  end

endmodule

//--- include/scp_pkg.sv
// ----------------------------------------------------------------------
// shared constants and types of the system clock prescaler
// ----------------------------------------------------------------------
package scp_pkg;

  // register offsets on the register port
  localparam logic [7:0] SCP_DIVCTL_OFS = 8'h61; // clock_divide_control
  localparam logic [7:0] SCP_CMDSTS_OFS = 8'h62; // clock_command_status
  localparam logic [7:0] SCP_TRIM_OFS = 8'h64; // rc_oscillator_trim

  // field positions
  localparam int SCP_UNLOCK_POS = 7; // change unlock bit, both registers
  localparam int SCP_READY_POS = 4; // source_ready_flag
  localparam int SCP_RANGE_POS = 7; // trim_range_select

  // unlock write value: unlock bit alone
  localparam logic [7:0] SCP_UNLOCK_PATTERN = 8'h80;

  // reset values and the largest legal code
  localparam logic [3:0] SCP_DIVSEL_RST_PLAIN = 4'h0; // fuse unprogrammed
  localparam logic [3:0] SCP_DIVSEL_RST_DIV8 = 4'h3; // fuse programmed
  localparam logic [3:0] SCP_CMD_RST = 4'h0; // command field
  localparam logic [3:0] SCP_DIVSEL_MAX = 4'h8; // largest legal code

  // unlock window, in master clock cycles
  localparam int SCP_UNLOCK_WINDOW_CYC = 4;

  // command codes; 1xxx means no command
  typedef enum logic [3:0] {
    SCP_CMD_NONE,
    SCP_CMD_DISABLE,
    SCP_CMD_ENABLE,
    SCP_CMD_AVAIL_REQ,
    SCP_CMD_SWITCH,
    SCP_CMD_RECOVER,
    SCP_CMD_WDOG_RELOAD,
    SCP_CMD_CLK_OUT
  } scp_cmd_t;

  // register port request
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // register offset
    logic [7:0] wdata; // write data
  } scp_bus_req_t;

  // active-edge enables of the four clock domains
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
  } scp_clk_en_t;

  // command issued to the clock switch logic
  typedef struct packed {
    logic valid; // one-cycle pulse
    scp_cmd_t code; // command
  } scp_cmd_out_t;

endpackage

//--- tb/tb_system_clock_prescaler.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// self-checking bench of the system clock prescaler
// ----------------------------------------------------------------------
module tb_system_clock_prescaler;
  // clock, reset and design ports
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  scp_pkg::scp_bus_req_t req_i = '0;
  logic [7:0] rdata_o;
  logic fuse_q = 1'b1; // divide-by-eight fuse strap
  logic [7:0] trim_factory_i = 8'h5A; // arbitrary factory trim
  logic avail_confirm_i = 1'b0;
  scp_pkg::scp_clk_en_t clk_en_o;
  logic [7:0] rc_oscillator_trim_o;
  scp_pkg::scp_cmd_out_t cmd_o;
  // bench bookkeeping
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] q; // last read data
  int g; // gap between active edges
  int t; // cycles since a divide write

  // 10 MHz master clock
  always #50 mclk_i = ~mclk_i;

  scp_prescaler u_scp_prescaler (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .startup_divide_by_eight_fuse_i(fuse_q),
    .trim_factory_i(trim_factory_i),
    .avail_confirm_i(avail_confirm_i),
    .clk_en_o(clk_en_o),
    .rc_oscillator_trim_o(rc_oscillator_trim_o),
    .cmd_o(cmd_o)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // compare and count; report a mismatch at once
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task conclude;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // move to just after the next rising edge
  task step;
    @(posedge mclk_i);
    #1;
  endtask

  // bus tasks leave their request standing; idle drops it
  task wr(input logic [7:0] a, input logic [7:0] d);
    req_i <= '{1'b1, 1'b0, a, d};
    step();
  endtask

  // read data stands in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    req_i <= '{1'b0, 1'b1, a, 8'h00};
    step();
    d = rdata_o;
  endtask

  task idle(input int n);
    req_i <= '0;
    repeat (n) step();
  endtask

  // reset with a given fuse strap, held 8 cycles
  task do_reset(input logic f);
    req_i <= '0;
    rst_i <= 1'b1;
    fuse_q <= f;
    repeat (8) step();
    rst_i <= 1'b0;
    step();
  endtask

  // cycles until the next active edge, bounded
  task next_pulse(output int n);
    n = 0;
    do begin
      step();
      n++;
    end while (clk_en_o.cpu !== 1'b1 && n < 1000);
  endtask

  // unlocked divide change, then let it settle
  task set_div(input logic [3:0] c);
    wr(8'h61, 8'h80);
    wr(8'h61, {4'h0, c});
    idle(1);
    repeat (3) next_pulse(g);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset values with the fuse programmed and unprogrammed
  task sc_reset;
    do_reset(1'b1);
    rd(8'h61, q);
    chk(q, 8'h03);
    rd(8'h64, q);
    chk(q, 8'h5A);
    idle(1);
    chk(rc_oscillator_trim_o, 8'h5A);
    repeat (2) next_pulse(g);
    chk(g, 8);
    do_reset(1'b0);
    rd(8'h61, q);
    chk(q, 8'h00);
    rd(8'h62, q);
    chk(q, 8'h00);
    idle(1);
  endtask

  // every legal code divides by two to its power, all domains alike
  task sc_factors;
    for (int c = 8; c >= 0; c--) begin
      set_div(c[3:0]);
      next_pulse(g);
      chk(g, 1 << c);
      chk(clk_en_o, 4'hF);
    end
  endtask

  // switch timing and no faster intermediate edge
  task sc_switch(input int o, input int n);
    int lo;
    lo = (o < n) ? o : n;
    set_div(o[3:0]);
    wr(8'h61, 8'h80);
    wr(8'h61, n[7:0]);
    idle(1);
    // the first pulse may end the old period part-way through our count,
    // so only the second one spans a whole period
    t = 1;
    next_pulse(g);
    t += g;
    next_pulse(g);
    t += g;
    chk(g >= (1 << lo), 1'b1);
    chk(t <= (1 << o) + 2 * (1 << n) + 2, 1'b1);
    next_pulse(g);
    chk(g, 1 << n);
  endtask

  // unlock pattern, window length and no extension
  task sc_unlock;
    set_div(4'h1);
    wr(8'h61, 8'h81);
    wr(8'h61, 8'h05);
    rd(8'h61, q);
    chk(q, 8'h01);
    wr(8'h61, 8'h80);
    rd(8'h61, q);
    chk(q, 8'h81);
    idle(3);
    wr(8'h61, 8'h05);
    rd(8'h61, q);
    chk(q, 8'h01);
    wr(8'h61, 8'h80);
    wr(8'h61, 8'h80);
    idle(2);
    wr(8'h61, 8'h02);
    rd(8'h61, q);
    chk(q, 8'h02);
    wr(8'h61, 8'h80);
    wr(8'h61, 8'h80);
    idle(3);
    wr(8'h61, 8'h06);
    rd(8'h61, q);
    chk(q, 8'h02);
    wr(8'h61, 8'h80);
    idle(2);
    wr(8'h61, 8'h03);
    rd(8'h61, q);
    chk(q, 8'h03);
    idle(1);
  endtask

  // reserved code stored but not applied; bits 6:4 read zero
  task sc_reserved;
    set_div(4'h2);
    wr(8'h61, 8'h80);
    wr(8'h61, 8'h7C);
    rd(8'h61, q);
    chk(q, 8'h0C);
    idle(1);
    repeat (2) next_pulse(g);
    chk(g, 4);
  endtask

  // every command code, ready flag and a refused unlock
  task sc_command;
    for (int c = 0; c < 16; c++) begin
      avail_confirm_i <= 1'b1;
      idle(1);
      avail_confirm_i <= 1'b0;
      wr(8'h62, 8'h80);
      wr(8'h62, c[7:0]);
      chk(cmd_o.valid, (c >= 1 && c <= 7));
      if (c >= 1 && c <= 7) begin
        chk(cmd_o.code, c[3:0]);
      end
      idle(1);
      chk(cmd_o.valid, 1'b0);
      rd(8'h62, q);
      chk(q, {3'b000, !(c == 2 || c == 3), c[3:0]});
    end
    wr(8'h62, 8'h84);
    wr(8'h62, 8'h05);
    chk(cmd_o.valid, 1'b0);
    idle(4);
    wr(8'h62, 8'h80);
    idle(4);
    wr(8'h62, 8'h05);
    chk(cmd_o.valid, 1'b0);
    idle(1);
  endtask

  // trim ranges and an unmapped place
  task sc_trim;
    wr(8'h64, 8'h7F);
    rd(8'h64, q);
    chk(q, 8'h7F);
    wr(8'h64, 8'h80);
    rd(8'h64, q);
    chk(q, 8'h80);
    idle(1);
    chk(rc_oscillator_trim_o, 8'h80);
    wr(8'h70, 8'hFF);
    rd(8'h70, q);
    chk(q, 8'h00);
    idle(1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    sc_reset();
    sc_factors();
    sc_switch(1, 3);
    sc_switch(3, 1);
    sc_unlock();
    sc_reserved();
    sc_trim();
    sc_command();
    conclude();
  end

  // cuts a hang short well beyond the expected run
  initial begin
    repeat (50000) @(posedge mclk_i);
    error_cnt++;
    conclude();
  end
endmodule
